/* mac_irq_pkg.sv */
package mac_irq_pkg;

    // Avalon-MM slave uses full 32-bit byte addresses.
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hfff030ac;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hfff030b0;
    localparam logic [31:0] START_DEMAND_ADDR = 32'hfff030b4;
    localparam logic [31:0] MAC_CTRL_ADDR = 32'hfff030b8;

    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Transmit flags occupy bits 24 down to 21 in the order of tx_evt_t.
    localparam int TX_FLAG_MSB = 24;
    localparam int TX_FLAG_LSB = 21;
    localparam int TX_SUMMARY_BIT = 16;
    localparam int RX_MASTER_BIT = 0;
    localparam int HALF_DUPLEX_BIT = 0;
    localparam int RESERVED_MSB = 31;
    localparam int RESERVED_LSB = 25;

    localparam logic [6:0] SLOT_BYTES = 7'h40;
    localparam logic [4:0] MAX_COLLISIONS = 5'h10;
    localparam logic [4:0] COLL_ONE = 5'h01;
    localparam logic [6:0] BYTE_ONE = 7'h01;

    typedef struct packed {
        logic bus_err;
        logic desc_unavail;
        logic late_col;
        logic abort;
    } tx_evt_t;

    localparam tx_evt_t NO_EVT = '{default: 1'b0};

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;

endpackage : mac_irq_pkg

/* collision_monitor.sv */
`timescale 1ns/100ps
module collision_monitor
    import mac_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic half_duplex,
    input wire logic tx_attempt_start,
    input wire logic tx_byte_sent,
    input wire logic tx_collision,
    input wire logic tx_frame_done,
    output logic late_col_ff,
    output logic abort_ff
);

    logic [6:0] byte_cnt_ff;
    logic [4:0] coll_cnt_ff;
    logic [6:0] nxt_byte_cnt;
    logic [4:0] nxt_coll_cnt;
    logic nxt_late_col;
    logic nxt_abort;

    wire past_slot = (byte_cnt_ff >= SLOT_BYTES);
    wire early_coll = half_duplex && tx_collision && !past_slot;
    wire [4:0] coll_inc = 5'(coll_cnt_ff + COLL_ONE);
    wire last_try = (coll_inc == MAX_COLLISIONS);

    // The byte count saturates at the slot size; nothing beyond it matters.
    assign nxt_byte_cnt = tx_attempt_start ? 7'h00 :
        (tx_byte_sent && !past_slot) ? 7'(byte_cnt_ff + BYTE_ONE) :
        byte_cnt_ff;
    // Only half-duplex collisions are counted or judged late.
    assign nxt_late_col = half_duplex && tx_collision && past_slot;
    assign nxt_abort = early_coll && last_try;
    // A successful frame ends the consecutive run, as does an abort.
    assign nxt_coll_cnt = (tx_frame_done || nxt_abort || !half_duplex) ?
        5'h00 : early_coll ? coll_inc : coll_cnt_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            byte_cnt_ff <= 7'h00;
            coll_cnt_ff <= 5'h00;
            late_col_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else if (ce) begin
            byte_cnt_ff <= nxt_byte_cnt;
            coll_cnt_ff <= nxt_coll_cnt;
            late_col_ff <= nxt_late_col;
            abort_ff <= nxt_abort;
        end
    end

    a_late_coll_seen: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && half_duplex && tx_collision && byte_cnt_ff >= SLOT_BYTES
        |=> late_col_ff)
        else $error("late collision missed");
    a_no_late_full: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && !half_duplex |=> !late_col_ff && !abort_ff)
        else $error("full duplex collision event");
    a_abort_at_16: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && half_duplex && tx_collision && !past_slot && !tx_frame_done
        && coll_cnt_ff == 5'h0f |=> abort_ff && coll_cnt_ff == 5'h00)
        else $error("abort not at sixteenth collision");
    a_abort_half_only: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        abort_ff |-> $past(half_duplex))
        else $error("abort outside half duplex");

endmodule : collision_monitor

/* mac_tx_interrupt_status.sv */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
// Contract
// - Writing one to a status flag clears it and its interrupt; zero keeps it.
// - The status flags are what raise the receive and transmit interrupts.
// - The status register comes out of reset with every flag cleared.
// - A memory error reply to a transmit DMA access sets the bus error flag.
// - Each transmit flag feeds the transmit summary only while enabled.
// - A missing transmit descriptor sets its flag and halts the DMA engine.
// - The halted DMA resumes only on a write to the start-demand register.
// - A collision after the first 64 bytes sets the late collision flag.
// - Late collisions are checked only in half-duplex mode.
// - Sixteen consecutive collisions abort the packet and set the abort flag.
// - Abort on excessive collisions is detected only in half-duplex mode.
// - The receive interrupt needs the receive summary and its master enable.
module mac_tx_interrupt_status
    import mac_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_dma_bus_error,
    input wire logic tx_desc_missing,
    input wire logic tx_attempt_start,
    input wire logic tx_byte_sent,
    input wire logic tx_collision,
    input wire logic tx_frame_done,
    input wire logic rx_irq_summary,
    output logic tx_dma_halted,
    output logic half_duplex,
    output logic tx_irq,
    output logic rx_irq
);

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] merge_write(input logic [31:0] old,
        input logic [31:0] wdata, input logic [3:0] be);
        merge_write = (old & ~lane_mask(be)) | (wdata & lane_mask(be));
    endfunction : merge_write

    bus_state_t bus_state_ff;
    bus_state_t nxt_bus_state;
    tx_evt_t flags_ff;
    tx_evt_t nxt_flags;
    tx_evt_t enables_ff;
    tx_evt_t nxt_enables;
    tx_evt_t set_evt;
    tx_evt_t clr_evt;
    logic rx_master_en_ff;
    logic nxt_rx_master_en;
    logic half_duplex_ff;
    logic nxt_half_duplex;
    logic halted_ff;
    logic nxt_halted;
    logic tx_irq_ff;
    logic rx_irq_ff;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic waitrequest_ff;
    logic late_col_pulse;
    logic abort_pulse;

    collision_monitor u_collision_monitor (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .half_duplex(half_duplex_ff),
        .tx_attempt_start(tx_attempt_start),
        .tx_byte_sent(tx_byte_sent),
        .tx_collision(tx_collision),
        .tx_frame_done(tx_frame_done),
        .late_col_ff(late_col_pulse),
        .abort_ff(abort_pulse)
    );

    // Each access is answered in the second cycle of its request: the first
    // cycle registers read data, so readdata comes straight from a flop.
    wire bus_req = avs_read || avs_write;
    wire bus_done = bus_req && (bus_state_ff == BUS_ACK);
    wire wr_done = bus_done && avs_write;
    wire hit_status = (avs_address == IRQ_STATUS_ADDR);
    wire hit_enable = (avs_address == IRQ_ENABLE_ADDR);
    wire hit_start = (avs_address == START_DEMAND_ADDR);
    wire hit_ctrl = (avs_address == MAC_CTRL_ADDR);
    wire [31:0] be_mask = lane_mask(avs_byteenable);
    wire [31:0] w1c_bits = avs_writedata & be_mask;

    always_comb begin
        case (bus_state_ff)
            BUS_IDLE: nxt_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
            BUS_ACK: nxt_bus_state = BUS_IDLE;
            default: nxt_bus_state = BUS_IDLE;
        endcase
    end

    assign set_evt = '{
        bus_err: tx_dma_bus_error,
        desc_unavail: tx_desc_missing,
        late_col: late_col_pulse,
        abort: abort_pulse
    };
    // Only bits 24..21 are writable flags; reserved bits are dropped.
    assign clr_evt = (wr_done && hit_status) ?
        tx_evt_t'(w1c_bits[TX_FLAG_MSB:TX_FLAG_LSB]) : NO_EVT;
    // A new event in the clearing cycle survives the clear.
    assign nxt_flags = (flags_ff & ~clr_evt) | set_evt;

    wire [31:0] enable_word = {7'h00, enables_ff, 4'h0, 16'h0000,
        rx_master_en_ff};
    wire [31:0] enable_merged = merge_write(enable_word, avs_writedata,
        avs_byteenable);
    assign nxt_enables = (wr_done && hit_enable) ?
        tx_evt_t'(enable_merged[TX_FLAG_MSB:TX_FLAG_LSB]) : enables_ff;
    assign nxt_rx_master_en = (wr_done && hit_enable) ?
        enable_merged[RX_MASTER_BIT] : rx_master_en_ff;

    wire [31:0] ctrl_word = {31'h0000_0000, half_duplex_ff};
    wire [31:0] ctrl_merged = merge_write(ctrl_word, avs_writedata,
        avs_byteenable);
    assign nxt_half_duplex = (wr_done && hit_ctrl) ?
        ctrl_merged[HALF_DUPLEX_BIT] : half_duplex_ff;

    // Any write to start-demand wakes the engine, whatever its data; a new
    // missing-descriptor report in that same cycle keeps it halted.
    wire start_demand = wr_done && hit_start;
    assign nxt_halted = tx_desc_missing ? 1'b1 :
        start_demand ? 1'b0 : halted_ff;

    wire tx_summary = |(flags_ff & enables_ff);
    wire [31:0] status_word = {7'h00, flags_ff, 4'h0, tx_summary, 15'h0000,
        rx_irq_summary};

    always_comb begin
        nxt_readdata = READ_ZERO;
        if (hit_status) begin
            nxt_readdata = status_word;
        end else if (hit_enable) begin
            nxt_readdata = enable_word;
        end else if (hit_ctrl) begin
            nxt_readdata = ctrl_word;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_ff <= BUS_IDLE;
            waitrequest_ff <= 1'b1;
            readdata_ff <= READ_ZERO;
        end else if (ce) begin
            bus_state_ff <= nxt_bus_state;
            waitrequest_ff <= !(bus_req && bus_state_ff == BUS_IDLE);
            readdata_ff <= (avs_read && bus_state_ff == BUS_IDLE) ?
                nxt_readdata : readdata_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_ff <= tx_evt_t'(STATUS_RESET[TX_FLAG_MSB:TX_FLAG_LSB]);
            enables_ff <= tx_evt_t'(ENABLE_RESET[TX_FLAG_MSB:TX_FLAG_LSB]);
            rx_master_en_ff <= ENABLE_RESET[RX_MASTER_BIT];
            half_duplex_ff <= CTRL_RESET[HALF_DUPLEX_BIT];
            halted_ff <= 1'b0;
        end else if (ce) begin
            flags_ff <= nxt_flags;
            enables_ff <= nxt_enables;
            rx_master_en_ff <= nxt_rx_master_en;
            half_duplex_ff <= nxt_half_duplex;
            halted_ff <= nxt_halted;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_irq_ff <= 1'b0;
            rx_irq_ff <= 1'b0;
        end else if (ce) begin
            tx_irq_ff <= |(nxt_flags & nxt_enables);
            rx_irq_ff <= rx_irq_summary && rx_master_en_ff;
        end
    end

    assign avs_readdata = readdata_ff;
    assign avs_waitrequest = waitrequest_ff;
    assign tx_dma_halted = halted_ff;
    assign half_duplex = half_duplex_ff;
    assign tx_irq = tx_irq_ff;
    assign rx_irq = rx_irq_ff;

    // Set beats clear: a flag whose own event repeats in the clearing
    // cycle stays up, so the clearing checks leave that case out.
    a_w1c_clears: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && wr_done && hit_status && avs_byteenable[3]
        && avs_writedata[TX_FLAG_MSB] && !tx_dma_bus_error
        |=> !flags_ff.bus_err)
        else $error("write one did not clear");
    a_w1c_desc: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && wr_done && hit_status && w1c_bits[TX_FLAG_MSB-1]
        && !tx_desc_missing |=> !flags_ff.desc_unavail)
        else $error("descriptor flag not cleared");
    a_w1c_late: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && wr_done && hit_status && w1c_bits[TX_FLAG_LSB+1]
        && !late_col_pulse |=> !flags_ff.late_col)
        else $error("late collision flag not cleared");
    a_w1c_abort: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && wr_done && hit_status && w1c_bits[TX_FLAG_LSB]
        && !abort_pulse |=> !flags_ff.abort)
        else $error("abort flag not cleared");
    a_w0_keeps: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && flags_ff.desc_unavail && !(wr_done && hit_status
        && w1c_bits[TX_FLAG_MSB-1]) |=> flags_ff.desc_unavail)
        else $error("flag lost without write one");
    // Looked at one edge after reset is seen, because the flops hold no
    // defined value before the first edge of a run.
    a_reset_clear: assert property (
        @(posedge sys_clk)
        !resetn |=> flags_ff == NO_EVT && !tx_irq_ff)
        else $error("status not clear after reset");
    a_bus_err_set: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && tx_dma_bus_error |=> flags_ff.bus_err)
        else $error("bus error flag not set");
    a_bus_err_quiet: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && !tx_dma_bus_error && !flags_ff.bus_err
        |=> !flags_ff.bus_err)
        else $error("bus error flag set without cause");
    a_irq_masked: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && (nxt_flags & nxt_enables) == NO_EVT
        |=> !tx_irq && !status_word[TX_SUMMARY_BIT])
        else $error("masked flag raised interrupt");
    a_irq_enabled: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && tx_dma_bus_error && enables_ff.bus_err
        && !(wr_done && hit_enable) |=> tx_irq)
        else $error("enabled flag silent");
    a_summary_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && avs_read && bus_state_ff == BUS_IDLE && hit_status
        |=> avs_readdata[TX_SUMMARY_BIT] == $past(tx_irq))
        else $error("summary bit disagrees with interrupt");
    a_late_flag_set: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && late_col_pulse |=> flags_ff.late_col)
        else $error("late collision flag not set");
    a_abort_flag_set: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && abort_pulse |=> flags_ff.abort)
        else $error("abort flag not set");
    a_halt_on_miss: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && tx_desc_missing |=> tx_dma_halted && flags_ff.desc_unavail)
        else $error("no halt on missing descriptor");
    a_halt_cause: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && !tx_dma_halted && !tx_desc_missing |=> !tx_dma_halted)
        else $error("halt without missing descriptor");
    a_halt_holds: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        tx_dma_halted && !start_demand |=> tx_dma_halted)
        else $error("halt left without start demand");
    a_halt_release: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && tx_dma_halted && start_demand && !tx_desc_missing
        |=> !tx_dma_halted)
        else $error("start demand ignored");
    a_rx_gated: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && !(rx_irq_summary && rx_master_en_ff) |=> !rx_irq)
        else $error("receive interrupt not gated");
    a_rx_raised: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && rx_irq_summary && rx_master_en_ff |=> rx_irq)
        else $error("receive interrupt not raised");
    a_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        avs_readdata[RESERVED_MSB:RESERVED_LSB] == 7'h00)
        else $error("reserved bits read nonzero");
    // Read data must stand until the next read is taken, since a slow
    // master may look at it late.
    a_readdata_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && !(avs_read && bus_state_ff == BUS_IDLE)
        |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_bus_answer: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ce && bus_req && bus_state_ff == BUS_IDLE |=> !avs_waitrequest
        ##1 (!ce || avs_waitrequest))
        else $error("bus answer late");

endmodule : mac_tx_interrupt_status

/* tb.sv */
`timescale 1ns/100ps
module tb
    import mac_irq_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] avs_address = 32'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic ce = 1'b1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // Event inputs: bus error, desc missing, attempt, byte, collision, done.
    logic [5:0] ev = 6'h00;
    logic rx_sum = 1'b0;
    logic tx_dma_halted;
    logic half_duplex;
    logic tx_irq;
    logic rx_irq;
    logic [31:0] q;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    mac_tx_interrupt_status dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .tx_dma_bus_error(ev[0]),
        .tx_desc_missing(ev[1]),
        .tx_attempt_start(ev[2]),
        .tx_byte_sent(ev[3]),
        .tx_collision(ev[4]),
        .tx_frame_done(ev[5]),
        .rx_irq_summary(rx_sum),
        .tx_dma_halted(tx_dma_halted),
        .half_duplex(half_duplex),
        .tx_irq(tx_irq),
        .rx_irq(rx_irq)
    );

    always #25 sys_clk = ~sys_clk;

    task tally_and_finish;
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Outputs are read right after the edge, before the design's updates
    // land, so the values seen are those the edge itself sampled.
    task acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
             input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc

    task wr(input logic [31:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hf);
    endtask : wr

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, 4'hf);
        chk(q, exp);
    endtask : rd_chk

    task step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step

    task pulse(input int idx);
        @(posedge sys_clk);
        ev[idx] <= 1'b1;
        @(posedge sys_clk);
        ev[idx] <= 1'b0;
    endtask : pulse

    task frame(input int nb, input int nc);
        pulse(2);
        repeat (nb) pulse(3);
        repeat (nc) pulse(4);
        step(4);
    endtask : frame

    initial begin
        step(6);
        resetn <= 1'b1;
        rd_chk(IRQ_STATUS_ADDR, STATUS_RESET);
        rd_chk(IRQ_ENABLE_ADDR, ENABLE_RESET);
        pulse(0);
        rd_chk(IRQ_STATUS_ADDR, 32'h0100_0000);
        chk({31'h0, tx_irq}, 32'h0);
        wr(IRQ_ENABLE_ADDR, 32'h01e0_0000);
        rd_chk(IRQ_ENABLE_ADDR, 32'h01e0_0000);
        rd_chk(IRQ_STATUS_ADDR, 32'h0101_0000);
        chk({31'h0, tx_irq}, 32'h1);
        wr(IRQ_STATUS_ADDR, 32'h0);
        rd_chk(IRQ_STATUS_ADDR, 32'h0101_0000);
        acc(1'b1, IRQ_STATUS_ADDR, 32'h0100_0000, 4'h7);
        rd_chk(IRQ_STATUS_ADDR, 32'h0101_0000);
        wr(IRQ_STATUS_ADDR, 32'h0100_0000);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        chk({31'h0, tx_irq}, 32'h0);
        pulse(1);
        step(2);
        chk({31'h0, tx_dma_halted}, 32'h1);
        rd_chk(IRQ_STATUS_ADDR, 32'h0081_0000);
        chk({31'h0, tx_dma_halted}, 32'h1);
        wr(START_DEMAND_ADDR, 32'h0);
        step(2);
        chk({31'h0, tx_dma_halted}, 32'h0);
        rd_chk(START_DEMAND_ADDR, READ_ZERO);
        wr(IRQ_STATUS_ADDR, 32'h0080_0000);
        frame(64, 1);
        frame(0, 16);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        wr(MAC_CTRL_ADDR, 32'h1);
        step(1);
        chk({31'h0, half_duplex}, 32'h1);
        frame(0, 15);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        frame(0, 1);
        rd_chk(IRQ_STATUS_ADDR, 32'h0021_0000);
        wr(IRQ_STATUS_ADDR, 32'h0020_0000);
        frame(63, 1);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        pulse(5);
        frame(64, 1);
        rd_chk(IRQ_STATUS_ADDR, 32'h0041_0000);
        chk({31'h0, tx_irq}, 32'h1);
        wr(IRQ_STATUS_ADDR, 32'h0040_0000);
        rx_sum <= 1'b1;
        step(3);
        chk({31'h0, rx_irq}, 32'h0);
        rd_chk(IRQ_STATUS_ADDR, 32'h1);
        wr(IRQ_ENABLE_ADDR, 32'h1);
        step(2);
        chk({31'h0, rx_irq}, 32'h1);
        wr(IRQ_ENABLE_ADDR, 32'h0);
        step(2);
        chk({31'h0, rx_irq}, 32'h0);
        wr(IRQ_STATUS_ADDR, 32'hfe00_0000);
        rd_chk(IRQ_STATUS_ADDR, 32'h1);
        wr(32'hfff0_3000, 32'hffff_ffff);
        rd_chk(32'hfff0_3000, READ_ZERO);
        rd_chk(IRQ_ENABLE_ADDR, 32'h0);
        // With the clock enable low an event must leave no trace.
        ce <= 1'b0;
        pulse(0);
        ce <= 1'b1;
        rd_chk(IRQ_STATUS_ADDR, 32'h1);
        pulse(0);
        rd_chk(IRQ_STATUS_ADDR, 32'h0100_0001);
        resetn <= 1'b0;
        step(2);
        resetn <= 1'b1;
        rd_chk(IRQ_STATUS_ADDR, 32'h1);
        chk({31'h0, half_duplex}, 32'h0);
        tally_and_finish();
    end
endmodule : tb
